// ==== logic/spcs_consts.svh ====
// Register offsets, field positions, reset values and divider counts of the serial port
`ifndef SPCS_CONSTS_SVH
`define SPCS_CONSTS_SVH

`define SPCS_OFF_DATA 2'h1
`define SPCS_OFF_CTRL 2'h2
`define SPCS_OFF_STAT 2'h3

`define SPCS_C_IRQ_EN 7
`define SPCS_C_PORT_EN 6
`define SPCS_C_HALF_DIS 5
`define SPCS_C_MASTER 4
`define SPCS_C_IDLE_LVL 3
`define SPCS_C_PHASE 2
`define SPCS_C_RATE_HI 1
`define SPCS_C_RATE_LO 0

`define SPCS_S_DONE 7
`define SPCS_S_WRITE_COLLISION_FLAG 6
`define SPCS_S_OVR 5
`define SPCS_S_MASTER_FAULT_FLAG 4
`define SPCS_S_SOD 2
`define SPCS_S_SSM 1
`define SPCS_S_SSI 0
`define SPCS_S_SW_MASK 8'h07

`define SPCS_CTRL_RST 8'h00
`define SPCS_STAT_RST 8'h00

// Half periods of the serial clock in system clock cycles
`define SPCS_HALF_DIV4 7'h02
`define SPCS_HALF_DIV8 7'h04
`define SPCS_HALF_DIV16 7'h08
`define SPCS_HALF_DIV32 7'h10
`define SPCS_HALF_DIV64 7'h20
`define SPCS_HALF_DIV128 7'h40

`define SPCS_LAST_EDGE 4'hf

`endif

// ==== logic/spcs_pkg.sv ====
// Types shared by the serial port control and status logic
package spcs_pkg;

   typedef logic [7:0] spcs_byte_t;
   typedef logic [1:0] spcs_addr_t;

   typedef enum logic [2:0] {
      SPCS_IDLE = 3'b001,
      SPCS_MASTER = 3'b010,
      SPCS_SLAVE = 3'b100
   } spcs_mode_t;

   typedef struct packed {
      spcs_byte_t ctrl;
      spcs_byte_t stat;
      logic done_armed;
      logic done_stat_read;
      logic write_collision_flag_armed;
      logic master_fault_flag_armed;
      spcs_byte_t buffer;
      spcs_byte_t shreg;
      logic rx_bit;
      logic [3:0] edge_cnt;
      logic sck_level;
      logic sck_prev;
      spcs_mode_t mode;
      spcs_byte_t rdata;
   } spcs_state_t;

endpackage

// ==== logic/spcs_sync.sv ====
// Two-flop synchroniser for the serial pins
module spcs_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_sys_i, // System clock
   input wire logic reset_n_i, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] async_i, // Pin levels from outside
   output logic [WIDTH-1:0] sync_o // Synchronised levels
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("spcs_sync needs WIDTH of at least 1");
      end
   endgenerate

   // The first stage feeds only the second stage
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule // spcs_sync

// ==== logic/spcs_clk_div.sv ====
// Serial clock divider giving one enable pulse per half period
module spcs_clk_div #(
   parameter int CNT_W = 7
) (
   input wire logic clk_sys_i, // System clock
   input wire logic reset_n_i, // Synchronous reset, active low
   input wire logic run_i, // Count while high, restart when low
   input wire logic [CNT_W-1:0] half_i, // Half period in cycles, at least 1
   output logic tick_o // One-cycle pulse at each serial clock edge
);
   logic [CNT_W-1:0] cnt_reg;
   logic at_end;

   generate
      if (CNT_W < 7) begin : g_bad_width
         $error("spcs_clk_div needs CNT_W of at least 7");
      end
   endgenerate

   assign at_end = (cnt_reg == (half_i - {{(CNT_W-1){1'b0}}, 1'b1}));
   assign tick_o = run_i && at_end;

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         cnt_reg <= '0;
      end else if (!run_i || at_end) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end
endmodule // spcs_clk_div

// ==== logic/spcs_top.sv ====
// Serial port control and status logic with byte shifter, master or slave
//
// The strobed register port and the placing of the registers were left to the implementer.
`include "spcs_consts.svh"

module spcs_top (
   input wire logic clk_sys_i, // System clock, 40 MHz
   input wire logic reset_n_i, // Synchronous reset, active low
   input wire spcs_pkg::spcs_addr_t reg_addr_i, // Register address
   input wire spcs_pkg::spcs_byte_t reg_wdata_i, // Register write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   output spcs_pkg::spcs_byte_t reg_rdata_o, // Read data, cycle after strobe
   output logic irq_o, // Interrupt request, active high
   input wire logic sck_i, // Serial clock pin level
   output logic sck_o, // Serial clock drive value
   output logic sck_oe_n_o, // Serial clock drive enable, active low
   input wire logic mosi_i, // Master-out pin level
   output logic mosi_o, // Master-out drive value
   output logic mosi_oe_n_o, // Master-out drive enable, active low
   input wire logic miso_i, // Master-in pin level
   output logic miso_o, // Master-in drive value
   output logic miso_oe_n_o, // Master-in drive enable, active low
   input wire logic ss_n_i, // Slave select pin, active low
   output logic ss_pin_free_o // High while the select pin is free for other use
);
   import spcs_pkg::*;

   localparam spcs_state_t ST_RST = '{
      ctrl: `SPCS_CTRL_RST,
      stat: `SPCS_STAT_RST,
      mode: SPCS_IDLE,
      default: '0
   };

   spcs_state_t q_reg;
   spcs_state_t q_next;
   logic [3:0] pin_s;
   logic [6:0] half_cnt;
   logic tick;
   logic c_en;
   logic c_master;
   logic c_phase;
   logic sel_n;
   logic rx_in;
   logic ev;
   logic sample_edge;
   logic busy;
   logic wr_inhibit;
   spcs_byte_t shifted;

   function automatic logic [6:0] rate_half(input logic [2:0] code);
      logic [6:0] h;
      h = `SPCS_HALF_DIV8;
      unique case (code)
         3'b100: h = `SPCS_HALF_DIV4;
         3'b000: h = `SPCS_HALF_DIV8;
         3'b001: h = `SPCS_HALF_DIV16;
         3'b110: h = `SPCS_HALF_DIV32;
         3'b010: h = `SPCS_HALF_DIV64;
         3'b011: h = `SPCS_HALF_DIV128;
         3'b101: h = `SPCS_HALF_DIV8;
         3'b111: h = `SPCS_HALF_DIV64;
      endcase
      return h;
   endfunction

   // Pin order: select, master-in, master-out, clock
   spcs_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .async_i({ss_n_i, miso_i, mosi_i, sck_i}),
      .sync_o(pin_s)
   );

   // Only the master state runs the divider, so the rate bits are inert as slave
   spcs_clk_div #(
      .CNT_W(7)
   ) u_div (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .run_i(q_reg.mode == SPCS_MASTER),
      .half_i(half_cnt),
      .tick_o(tick)
   );

   assign c_en = q_reg.ctrl[`SPCS_C_PORT_EN];
   assign c_master = q_reg.ctrl[`SPCS_C_MASTER];
   assign c_phase = q_reg.ctrl[`SPCS_C_PHASE];
   assign half_cnt = rate_half({q_reg.ctrl[`SPCS_C_HALF_DIS],
                                q_reg.ctrl[`SPCS_C_RATE_HI],
                                q_reg.ctrl[`SPCS_C_RATE_LO]});

   always_comb begin
      q_next = q_reg;
      q_next.rdata = 8'h00;
      q_next.sck_prev = pin_s[0];
      sel_n = q_reg.stat[`SPCS_S_SSM] ? q_reg.stat[`SPCS_S_SSI] : pin_s[3];
      rx_in = (q_reg.mode == SPCS_MASTER) ? pin_s[2] : pin_s[1];
      busy = (q_reg.mode == SPCS_MASTER) ||
             ((q_reg.mode == SPCS_SLAVE) && (q_reg.edge_cnt != 4'h0));
      wr_inhibit = q_reg.stat[`SPCS_S_DONE] && !q_reg.done_stat_read;
      sample_edge = (q_reg.edge_cnt[0] == c_phase);
      shifted = {q_reg.shreg[6:0], sample_edge ? rx_in : q_reg.rx_bit};
      ev = 1'b0;
      if (q_reg.mode == SPCS_MASTER) begin
         ev = tick;
      end else if (q_reg.mode == SPCS_SLAVE) begin
         ev = (pin_s[0] != q_reg.sck_prev);
      end

      // Register reads: clears first, so hardware sets below win
      if (reg_rd_i) begin
         case (reg_addr_i)
            `SPCS_OFF_DATA: begin
               q_next.rdata = q_reg.buffer;
               if (q_reg.done_armed) begin
                  q_next.stat[`SPCS_S_DONE] = 1'b0;
               end
               if (q_reg.write_collision_flag_armed) begin
                  q_next.stat[`SPCS_S_WRITE_COLLISION_FLAG] = 1'b0;
               end
            end
            `SPCS_OFF_CTRL: begin
               q_next.rdata = q_reg.ctrl;
            end
            `SPCS_OFF_STAT: begin
               q_next.rdata = q_reg.stat;
               q_next.stat[`SPCS_S_OVR] = 1'b0;
               q_next.done_armed = q_reg.stat[`SPCS_S_DONE];
               q_next.done_stat_read = q_reg.stat[`SPCS_S_DONE];
               q_next.write_collision_flag_armed = q_reg.stat[`SPCS_S_WRITE_COLLISION_FLAG];
               q_next.master_fault_flag_armed = q_reg.stat[`SPCS_S_MASTER_FAULT_FLAG];
            end
            default: begin
               q_next.rdata = 8'h00;
            end
         endcase
      end

      // Register writes
      if (reg_wr_i) begin
         case (reg_addr_i)
            `SPCS_OFF_DATA: begin
               if (q_reg.done_armed) begin
                  q_next.stat[`SPCS_S_DONE] = 1'b0;
               end
               // A data write during a transfer sets the collision flag, unless done is set and not yet seen in a status read, and leaves its arming alone
               if (!wr_inhibit) begin
                  if (busy) begin
                     q_next.stat[`SPCS_S_WRITE_COLLISION_FLAG] = 1'b1;
                  end else begin
                     q_next.shreg = reg_wdata_i;
                     if (c_en && c_master) begin
                        q_next.mode = SPCS_MASTER;
                        q_next.edge_cnt = 4'h0;
                     end
                  end
               end
            end
            `SPCS_OFF_CTRL: begin
               q_next.ctrl = reg_wdata_i;
               if (q_reg.stat[`SPCS_S_MASTER_FAULT_FLAG] && !q_reg.master_fault_flag_armed) begin
                  q_next.ctrl[`SPCS_C_PORT_EN] = c_en;
                  q_next.ctrl[`SPCS_C_MASTER] = c_master;
               end
               if (q_reg.master_fault_flag_armed) begin
                  q_next.stat[`SPCS_S_MASTER_FAULT_FLAG] = 1'b0;
               end
            end
            `SPCS_OFF_STAT: begin
               // Flags and the reserved bit are read only
               q_next.stat = (q_next.stat & ~`SPCS_S_SW_MASK) |
                             (reg_wdata_i & `SPCS_S_SW_MASK);
               q_next.done_armed = q_reg.stat[`SPCS_S_DONE];
               q_next.master_fault_flag_armed = q_reg.stat[`SPCS_S_MASTER_FAULT_FLAG];
            end
            default: begin
            end
         endcase
      end

      // Byte engine
      unique case (q_reg.mode)
         SPCS_IDLE: begin
            q_next.sck_level = q_reg.ctrl[`SPCS_C_IDLE_LVL];
            q_next.edge_cnt = 4'h0;
            if (c_en && !c_master && !sel_n) begin
               q_next.mode = SPCS_SLAVE;
            end
         end
         SPCS_MASTER: begin
            if (!c_en || !c_master) begin
               q_next.mode = SPCS_IDLE;
            end else if (ev) begin
               q_next.sck_level = ~q_reg.sck_level;
            end
         end
         SPCS_SLAVE: begin
            if (!c_en || c_master || sel_n) begin
               q_next.mode = SPCS_IDLE;
            end
         end
      endcase

      if (ev && (q_next.mode == q_reg.mode)) begin
         if (sample_edge) begin
            q_next.rx_bit = rx_in;
         end
         if (q_reg.edge_cnt == `SPCS_LAST_EDGE) begin
            q_next.shreg = shifted;
            if (q_reg.stat[`SPCS_S_DONE]) begin
               q_next.stat[`SPCS_S_OVR] = 1'b1;
            end else begin
               q_next.buffer = shifted;
            end
            q_next.stat[`SPCS_S_DONE] = 1'b1;
            q_next.done_armed = 1'b0;
            q_next.done_stat_read = 1'b0;
            q_next.edge_cnt = 4'h0;
            if (q_reg.mode == SPCS_MASTER) begin
               q_next.mode = SPCS_IDLE;
            end
         end else begin
            // With phase 1 the first transition only presents the MSB
            if (!sample_edge && !(c_phase && (q_reg.edge_cnt == 4'h0))) begin
               q_next.shreg = shifted;
            end
            q_next.edge_cnt = q_reg.edge_cnt + 4'h1;
         end
      end

      // Mode fault: hardware clear beats any software write in the same cycle
      if (c_master && !sel_n) begin
         q_next.stat[`SPCS_S_MASTER_FAULT_FLAG] = 1'b1;
         q_next.master_fault_flag_armed = 1'b0;
         q_next.ctrl[`SPCS_C_PORT_EN] = 1'b0;
         q_next.ctrl[`SPCS_C_MASTER] = 1'b0;
         q_next.mode = SPCS_IDLE;
      end

      if (!q_next.stat[`SPCS_S_DONE]) begin
         q_next.done_armed = 1'b0;
         q_next.done_stat_read = 1'b0;
      end
      if (!q_next.stat[`SPCS_S_WRITE_COLLISION_FLAG]) begin
         q_next.write_collision_flag_armed = 1'b0;
      end
      if (!q_next.stat[`SPCS_S_MASTER_FAULT_FLAG]) begin
         q_next.master_fault_flag_armed = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         q_reg <= ST_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   assign reg_rdata_o = q_reg.rdata;
   assign irq_o = q_reg.ctrl[`SPCS_C_IRQ_EN] &&
                  (q_reg.stat[`SPCS_S_DONE] || q_reg.stat[`SPCS_S_MASTER_FAULT_FLAG] ||
                   q_reg.stat[`SPCS_S_OVR]);
   assign sck_o = q_reg.sck_level;
   assign sck_oe_n_o = !(c_en && c_master);
   assign mosi_o = q_reg.shreg[7];
   assign mosi_oe_n_o = !(c_en && c_master && !q_reg.stat[`SPCS_S_SOD]);
   assign miso_o = q_reg.shreg[7];
   // A slave drives its output only while selected, so several slaves may share it
   assign miso_oe_n_o = !(c_en && !c_master && !q_reg.stat[`SPCS_S_SOD] &&
                          (q_reg.mode == SPCS_SLAVE));
   assign ss_pin_free_o = q_reg.stat[`SPCS_S_SSM] || !c_en;
endmodule // spcs_top

// ==== verif/spcs_props.sv ====
// Concurrent checks on the serial port's register bus, interrupt and pin enables
`include "spcs_consts.svh"
module spcs_props (
   input wire logic clk_sys_i, // System clock
   input wire logic reset_n_i, // Reset, active low
   input wire spcs_pkg::spcs_addr_t reg_addr_i, // Address
   input wire spcs_pkg::spcs_byte_t reg_wdata_i, // Write data
   input wire logic reg_wr_i, // Write strobe
   input wire logic reg_rd_i, // Read strobe
   input wire spcs_pkg::spcs_byte_t reg_rdata_o, // Read data
   input wire logic irq_o, // Interrupt
   input wire logic sck_o, // Clock value
   input wire logic sck_oe_n_o, // Clock enable
   input wire logic mosi_oe_n_o, // Master-out enable
   input wire logic miso_oe_n_o, // Master-in enable
   input wire logic ss_n_i, // Select pin
   input wire logic ss_pin_free_o // Select pin free
);
   timeunit 1ns;
   timeprecision 100ps;
   import spcs_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   logic irq_en_q, sod_q, ssm_q, sck_q;
   logic [2:0] code_q;
   logic [6:0] gap_q;
   logic [3:0] tgl_q;
   wire ctrl_wr = reg_wr_i && reg_addr_i == `SPCS_OFF_CTRL;
   wire stat_wr = reg_wr_i && reg_addr_i == `SPCS_OFF_STAT;
   function automatic logic [6:0] half_of(input logic [2:0] c);
      case (c)
         3'h4: return 7'h02;
         3'h0, 3'h5: return 7'h04;
         3'h1: return 7'h08;
         3'h6: return 7'h10;
         3'h2, 3'h7: return 7'h20;
         default: return 7'h40;
      endcase
   endfunction
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         {irq_en_q, sod_q, ssm_q, sck_q} <= 4'h0;
         code_q <= 3'h0;
         gap_q <= 7'h00;
         tgl_q <= 4'h0;
      end else begin
         if (ctrl_wr) begin
            irq_en_q <= reg_wdata_i[7];
            code_q <= {reg_wdata_i[5], reg_wdata_i[1:0]};
         end
         if (stat_wr) begin
            sod_q <= reg_wdata_i[2];
            ssm_q <= reg_wdata_i[1];
         end
         sck_q <= sck_o;
         // Counts cycles since the last clock toggle; saturates between frames
         gap_q <= (sck_o != sck_q) ? 7'h00 : gap_q + {6'h0, gap_q != 7'h7f};
         tgl_q <= tgl_q + {3'h0, sck_o != sck_q};
      end
   end
   sequence fault_seen;
      !sck_oe_n_o && !ss_n_i && !ssm_q;
   endsequence
   chk_irq_masked: assert property (!irq_en_q |-> !irq_o)
      else $error("interrupt raised while disabled");
   chk_sck_rate: assert property ((sck_o != sck_q) && tgl_q != 4'h0 |->
      gap_q == half_of(code_q) - 7'h01)
      else $error("serial clock half period wrong");
   chk_fault_drop: assert property (fault_seen |-> ##[1:6] (sck_oe_n_o && mosi_oe_n_o))
      else $error("master kept driving after select low");
   chk_role_swap: assert property (!sck_oe_n_o |-> miso_oe_n_o)
      else $error("master drives master-in pin");
   chk_master_off: assert property (ctrl_wr && !reg_wdata_i[4] |=> ##[0:1] sck_oe_n_o)
      else $error("clock driven in slave mode");
   chk_out_disable: assert property (sod_q && $past(sod_q) |-> mosi_oe_n_o && miso_oe_n_o)
      else $error("serial output driven while disabled");
   chk_pin_free: assert property (ssm_q && $past(ssm_q) |-> ss_pin_free_o)
      else $error("select pin held under soft select");
   chk_unmapped_read: assert property (reg_rd_i && reg_addr_i == 2'h0 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_stat_reserved: assert property (reg_rd_i && reg_addr_i == `SPCS_OFF_STAT |=>
      !reg_rdata_o[3])
      else $error("reserved status bit set");
endmodule // spcs_props

bind spcs_top spcs_props spcs_props_inst (.clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .sck_o, .sck_oe_n_o, .mosi_oe_n_o,
   .miso_oe_n_o, .ss_n_i, .ss_pin_free_o);

// ==== verif/spcs_peer.sv ====
// Behavioural external slave on the serial link, clock idle low, capture on first edge
module spcs_peer (
   input wire logic sck_i, // Serial clock
   input wire logic mosi_i, // Data from master
   output logic miso_o, // Data to master
   output spcs_pkg::spcs_byte_t rx_o // Last byte in
);
   timeunit 1ns;
   timeprecision 100ps;
   import spcs_pkg::*;
   spcs_byte_t tx_sh = 8'h00;
   initial rx_o = 8'h00;
   assign miso_o = tx_sh[7];
   always @(posedge sck_i) rx_o <= {rx_o[6:0], mosi_i};
   // Spent bits come back inverted so a stale line never looks like fresh data
   always @(negedge sck_i) tx_sh <= {tx_sh[6:0], ~tx_sh[7]};
   task automatic load(input spcs_byte_t b);
      tx_sh = b;
   endtask
endmodule // spcs_peer

// ==== verif/spcs_top_tb_top.sv ====
// Self-checking testbench of the serial port control and status block
`include "spcs_consts.svh"
module spcs_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import spcs_pkg::*;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   spcs_addr_t addr = 2'h0;
   spcs_byte_t wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic ss_n = 1'b1;
   logic sck_tb = 1'b0;
   logic mosi_tb = 1'b1;
   spcs_byte_t rdata, prx, got;
   logic irq, sck, sck_oe_n, mosi, mosi_oe_n, miso, miso_oe_n, ss_free, peer_miso;
   int err_total = 0;
   int checks_done = 0;
   localparam logic [2:0] codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
   wire sck_w = sck_oe_n ? sck_tb : sck; // Bench clocks a slave port, idles low
   wire mosi_w = mosi_oe_n ? mosi_tb : mosi; // Bench data, idles high
   wire miso_w = miso_oe_n ? peer_miso : miso;
   spcs_top spcs_top_inst (.clk_sys_i, .reset_n_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .irq_o(irq), .sck_i(sck_w),
      .sck_o(sck), .sck_oe_n_o(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi),
      .mosi_oe_n_o(mosi_oe_n), .miso_i(miso_w), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
      .ss_n_i(ss_n), .ss_pin_free_o(ss_free));
   spcs_peer spcs_peer_inst (.sck_i(sck_w), .mosi_i(mosi_w), .miso_o(peer_miso), .rx_o(prx));
   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic chk(input string n, input spcs_byte_t e, input spcs_byte_t g);
      checks_done++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   task automatic wr(input spcs_addr_t a, input spcs_byte_t d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_sys_i);
      wr_s <= 1'b0;
   endtask
   // An empty name reads without comparing, for bytes sampled too fast to predict
   task automatic rd(input spcs_addr_t a, input spcs_byte_t e, input string n);
      @(posedge clk_sys_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys_i);
      rd_s <= 1'b0;
      #1;
      if (n != "") chk(n, e, rdata);
   endtask
   task automatic wait_irq();
      int k;
      k = 0;
      cyc(1);
      while (irq !== 1'b1 && k < 3000) begin
         cyc(1);
         k++;
      end
      chk("irq raised", 8'h01, {7'h00, irq});
   endtask
   task automatic half(input int h);
      int k;
      logic s;
      for (int j = 0; j < 2; j++) begin
         s = sck;
         k = 0;
         while (sck === s && k < 300) begin
            cyc(1);
            k++;
         end
      end
      chk("sck half period", h[7:0], k[7:0]);
   endtask
   // Bench as link master: phase 0 captures on the rising edge, phase 1 on the falling one
   task automatic slave_byte(input spcs_byte_t d, input logic ph, output spcs_byte_t q);
      for (int b = 7; b >= 0; b--) begin
         sck_tb <= ph;
         mosi_tb <= d[b];
         repeat (8) @(posedge clk_sys_i);
         q = {q[6:0], miso_w};
         sck_tb <= !ph;
         repeat (8) @(posedge clk_sys_i);
      end
      sck_tb <= 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      rd(`SPCS_OFF_CTRL, 8'h00, "control reset");
      rd(`SPCS_OFF_STAT, 8'h00, "status reset");
      rd(2'h0, 8'h00, "unmapped");
      chk("pins at reset", 8'h03, {6'h00, sck_oe_n, ss_free});
      wr(`SPCS_OFF_STAT, 8'hf7);
      rd(`SPCS_OFF_STAT, 8'h07, "status writable");
      wr(`SPCS_OFF_STAT, 8'h00);
      spcs_peer_inst.load(8'h3c);
      wr(`SPCS_OFF_CTRL, 8'hd1);
      wr(`SPCS_OFF_DATA, 8'ha5);
      cyc(2);
      chk("master pins", 8'h01, {5'h00, sck_oe_n, mosi_oe_n, miso_oe_n});
      wait_irq();
      chk("peer rx", 8'ha5, prx);
      wr(`SPCS_OFF_DATA, 8'h5a);
      cyc(40);
      rd(`SPCS_OFF_STAT, 8'h80, "done held");
      chk("peer rx kept", 8'ha5, prx);
      rd(`SPCS_OFF_DATA, 8'h3c, "master rx");
      rd(`SPCS_OFF_STAT, 8'h00, "done cleared");
      chk("irq low", 8'h00, {7'h00, irq});
      spcs_peer_inst.load(8'h96);
      wr(`SPCS_OFF_DATA, 8'hc3);
      cyc(20);
      wr(`SPCS_OFF_DATA, 8'h11);
      wait_irq();
      chk("collided byte dropped", 8'hc3, prx);
      rd(`SPCS_OFF_STAT, 8'hc0, "collision set");
      wr(`SPCS_OFF_DATA, 8'h22);
      wait_irq();
      chk("second byte out", 8'h22, prx);
      rd(`SPCS_OFF_STAT, 8'hc0, "collision kept");
      rd(`SPCS_OFF_DATA, 8'h69, "second byte in");
      rd(`SPCS_OFF_STAT, 8'h00, "flags cleared");
      for (int i = 0; i < 6; i++) begin
         wr(`SPCS_OFF_CTRL, {2'h3, codes[i][2], 3'h4, codes[i][1:0]});
         wr(`SPCS_OFF_DATA, 8'h00);
         half(2 << i);
         wait_irq();
         rd(`SPCS_OFF_STAT, 8'h80, "rate done");
         rd(`SPCS_OFF_DATA, 8'h00, "");
      end
      wr(`SPCS_OFF_CTRL, 8'h50);
      ss_n <= 1'b0;
      cyc(8);
      rd(`SPCS_OFF_CTRL, 8'h00, "fault drops control");
      wr(`SPCS_OFF_CTRL, 8'h50);
      rd(`SPCS_OFF_CTRL, 8'h00, "set refused");
      ss_n <= 1'b1;
      cyc(4);
      rd(`SPCS_OFF_STAT, 8'h10, "fault flag");
      wr(`SPCS_OFF_CTRL, 8'h50);
      rd(`SPCS_OFF_STAT, 8'h00, "fault cleared");
      rd(`SPCS_OFF_CTRL, 8'h50, "control restored");
      wr(`SPCS_OFF_STAT, 8'h07);
      ss_n <= 1'b0;
      cyc(8);
      chk("soft select pins", 8'h03, {6'h00, mosi_oe_n, ss_free});
      rd(`SPCS_OFF_STAT, 8'h07, "pin ignored");
      wr(`SPCS_OFF_STAT, 8'h02);
      cyc(4);
      rd(`SPCS_OFF_STAT, 8'h12, "internal select fault");
      wr(`SPCS_OFF_CTRL, 8'hc0);
      wr(`SPCS_OFF_DATA, 8'h3a);
      cyc(1);
      chk("slave pins", 8'h01, {6'h00, miso_oe_n, sck_oe_n});
      slave_byte(8'hc5, 1'b0, got);
      wait_irq();
      chk("slave tx", 8'h3a, got);
      slave_byte(8'h0f, 1'b0, got);
      cyc(4);
      chk("slave echo", 8'hc5, got);
      rd(`SPCS_OFF_STAT, 8'ha2, "overrun set");
      rd(`SPCS_OFF_DATA, 8'hc5, "overrun keeps first");
      rd(`SPCS_OFF_STAT, 8'h02, "overrun cleared");
      wr(`SPCS_OFF_CTRL, 8'hc4);
      wr(`SPCS_OFF_DATA, 8'h5c);
      slave_byte(8'h93, 1'b1, got);
      wait_irq();
      chk("slave phase 1 tx", 8'h5c, got);
      rd(`SPCS_OFF_STAT, 8'h82, "slave done");
      rd(`SPCS_OFF_DATA, 8'h93, "slave phase 1 rx");
      wr(`SPCS_OFF_CTRL, 8'h84);
      wr(`SPCS_OFF_CTRL, 8'h8c);
      cyc(2);
      chk("idle level high", 8'h01, {7'h00, sck});
      test_done();
   end
   // Whole sequence needs about 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      $display("[FAIL] watchdog expected end seen hang");
      test_done();
   end
endmodule // spcs_top_tb_top
